// ### rtl/spc_consts.svh
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// register byte offsets on the control bus
`define SPC_OFF_CTRL1   8'h00
`define SPC_OFF_CTRL2   8'h04
`define SPC_OFF_STAT    8'h08
`define SPC_OFF_BUF     8'h0C

// implemented bits of each control register
`define SPC_MASK_CTRL1  16'h1FFF
`define SPC_MASK_CTRL2  16'hE002

// reset value of every implemented control bit
`define SPC_CTRL_RST    16'h0000

// first control register fields
`define SPC_C1_CLKDIS   12
`define SPC_C1_SDODIS   11
`define SPC_C1_WIDE     10
`define SPC_C1_SMP      9
`define SPC_C1_CKE      8
`define SPC_C1_SELECT_PIN_ENABLE     7
`define SPC_C1_CKP      6
`define SPC_C1_MASTER_ENABLE    5
`define SPC_C1_SEC_HI   4
`define SPC_C1_SEC_LO   2
`define SPC_C1_PRI_HI   1
`define SPC_C1_PRI_LO   0

// second control register fields
`define SPC_C2_FRAMED_ENABLE    15
`define SPC_C2_FSD      14
`define SPC_C2_FPOL     13
`define SPC_C2_FDLY     1

// status register fields
`define SPC_ST_EN       15
`define SPC_ST_ROV      6
`define SPC_ST_TBF      1
`define SPC_ST_RBF      0

// half-clock and bit counts of one word
`define SPC_HALF16      6'd32
`define SPC_HALF8       6'd16
`define SPC_BITS16      5'd16
`define SPC_BITS8       5'd8

// bus responses
`define SPC_RESP_OKAY   2'b00
`define SPC_RESP_SLVERR 2'b10

`endif

// ### rtl/spc_pkg.sv
package spc_pkg;

  typedef enum logic [1:0] {MS_IDLE, MS_SYNC, MS_SHIFT} spc_mstate_e;

  typedef struct packed {
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic        sck_d;
    logic [15:0] ctrl1;
    logic [15:0] ctrl2;
    logic        en;
    logic        rov;
    logic        tbf;
    logic        rbf;
    logic [15:0] txb;
    logic [15:0] rxb;
    logic [15:0] sr;
    logic [15:0] rx;
    spc_mstate_e mstate;
    logic [5:0]  h;
    logic        sck;
    logic        fs;
    logic [4:0]  scnt;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  raddr;
  } spc_state_s;

  typedef struct packed {
    logic [9:0] cnt;
  } spc_div_s;

endpackage

// ### rtl/spc_clkdiv.sv
`timescale 1ns/1ps
module spc_clkdiv
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // divider control
  input  wire logic       run,
  input  wire logic [1:0] pri,
  input  wire logic [2:0] sec,
  // half-period strobe
  output logic            tick
);

  spc_pkg::spc_div_s st_r;
  spc_pkg::spc_div_s st_nxt;
  logic [6:0]        pri_ratio;
  logic [3:0]        sec_ratio;
  logic [9:0]        ratio;
  logic [9:0]        half;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    pri_ratio = 7'(7'h01 << {~pri, 1'b0});
    sec_ratio = 4'h8 - {1'b0, sec};
    ratio = {3'h0, pri_ratio} * {6'h00, sec_ratio};
    // odd ratios split unevenly; the period stays exact except at 1:1, where a tick every cycle gives a two-cycle period
    half = ratio >> 1;
    st_nxt = st_r;
    if (!run)
      st_nxt.cnt = 10'h000;
    else if (st_r.cnt + 10'h001 >= ratio)
      st_nxt.cnt = 10'h000;
    else
      st_nxt.cnt = st_r.cnt + 10'h001;
    tick = run && (st_r.cnt == 10'h000 || st_r.cnt == half);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  cnt_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    run |-> st_r.cnt < ratio)
    else $error("divider count outside ratio");

  slow_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (run && pri == 2'h0 && sec == 3'h7 && st_r.cnt == 10'h000) |=>
      (!tick)[*8])
    else $error("primary 64:1 ticks too often");

endmodule

// ### rtl/spc_top.sv
`timescale 1ns/1ps
`include "spc_consts.svh"
module spc_top
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // axi4-lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // serial clock pin
  input  wire logic        SERIAL_CLOCK_PIN_I,
  output logic             SERIAL_CLOCK_PIN_O,
  output logic             SERIAL_CLOCK_PIN_OE,
  // serial data pins
  output logic             SERIAL_DATA_OUT_PIN_O,
  output logic             SERIAL_DATA_OUT_PIN_OE,
  input  wire logic        SERIAL_DATA_IN_PIN_I,
  // select or frame sync pin, select sense is active low
  input  wire logic        SLAVE_SELECT_PIN_N_I,
  output logic             SLAVE_SELECT_PIN_N_O,
  output logic             SLAVE_SELECT_PIN_N_OE
);

  spc_pkg::spc_state_s st_r;
  spc_pkg::spc_state_s st_nxt;
  logic                tick;
  logic                master;
  logic                cke_eff;
  logic                select_pin_enable_eff;
  logic                fr_out;
  logic                fr_in;
  logic                fr_act;
  logic                sel;
  logic [5:0]          two_b;
  logic [4:0]          nbits;
  logic                chg_m;
  logic                samp_m;
  logic                shift_m;
  logic                s_lead;
  logic                s_trail;
  logic                s_chg;
  logic                s_smp;
  logic                deliver;
  logic                rov_set;
  logic [15:0]         wmerge;

  //////////////////////////////////////////////////////////////////////////
  // master or slave
  assign master   = st_r.ctrl1[`SPC_C1_MASTER_ENABLE];
  assign cke_eff  = st_r.ctrl1[`SPC_C1_CKE] && !st_r.ctrl2[`SPC_C2_FRAMED_ENABLE];
  assign select_pin_enable_eff = st_r.ctrl1[`SPC_C1_SELECT_PIN_ENABLE] && !st_r.ctrl2[`SPC_C2_FRAMED_ENABLE];
  assign fr_out   = st_r.ctrl2[`SPC_C2_FRAMED_ENABLE] && !st_r.ctrl2[`SPC_C2_FSD];
  assign fr_in    = st_r.ctrl2[`SPC_C2_FRAMED_ENABLE] && st_r.ctrl2[`SPC_C2_FSD];
  assign fr_act   = st_r.s2[0] == st_r.ctrl2[`SPC_C2_FPOL];
  assign sel      = !select_pin_enable_eff || !st_r.s2[0];
  assign two_b    = st_r.ctrl1[`SPC_C1_WIDE] ? `SPC_HALF16 : `SPC_HALF8;
  assign nbits    = st_r.ctrl1[`SPC_C1_WIDE] ? `SPC_BITS16 : `SPC_BITS8;
  // even half ticks are leading edges, odd ones trailing
  assign chg_m    = cke_eff ? st_r.h[0] : !st_r.h[0];
  // end of bit or middle of bit
  assign samp_m   = st_r.ctrl1[`SPC_C1_SMP] ? (chg_m && st_r.h != 6'h00)
                                            : (!chg_m && st_r.h != two_b);
  assign shift_m  = chg_m && st_r.h != 6'h00 && st_r.h != two_b;
  // slave edges named against the idle level
  assign s_lead   = st_r.ctrl1[`SPC_C1_CKP] ? (!st_r.s2[2] && st_r.sck_d)
                                            : (st_r.s2[2] && !st_r.sck_d);
  assign s_trail  = st_r.ctrl1[`SPC_C1_CKP] ? (st_r.s2[2] && !st_r.sck_d)
                                            : (!st_r.s2[2] && st_r.sck_d);
  assign s_chg    = cke_eff ? s_trail : s_lead;
  assign s_smp    = cke_eff ? s_lead : s_trail;

  spc_clkdiv u_div
  (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .run   (st_r.mstate != spc_pkg::MS_IDLE),
    .pri   (st_r.ctrl1[`SPC_C1_PRI_HI:`SPC_C1_PRI_LO]),
    .sec   (st_r.ctrl1[`SPC_C1_SEC_HI:`SPC_C1_SEC_LO]),
    .tick  (tick)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt  = st_r;
    deliver = 1'b0;
    rov_set = 1'b0;
    wmerge  = 16'h0000;
    // pin synchronisers: first stage feeds only the second
    st_nxt.s1    = {SERIAL_CLOCK_PIN_I, SERIAL_DATA_IN_PIN_I, SLAVE_SELECT_PIN_N_I};
    st_nxt.s2    = st_r.s1;
    st_nxt.sck_d = st_r.s2[2];

    // read channel first, so a buffer read clears full before new data lands
    if (S_AXI_ARVALID && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `SPC_RESP_OKAY;
      st_nxt.raddr  = S_AXI_ARADDR;
      unique case (S_AXI_ARADDR)
        `SPC_OFF_CTRL1: st_nxt.rdata = {16'h0000, st_r.ctrl1 & `SPC_MASK_CTRL1};
        `SPC_OFF_CTRL2: st_nxt.rdata = {16'h0000, st_r.ctrl2 & `SPC_MASK_CTRL2};
        `SPC_OFF_STAT:  st_nxt.rdata = {16'h0000, st_r.en, 8'h00, st_r.rov,
                                        4'h0, st_r.tbf, st_r.rbf};
        `SPC_OFF_BUF:
        begin
          st_nxt.rdata = {16'h0000, st_r.rxb};
          st_nxt.rbf   = 1'b0;
        end
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = `SPC_RESP_SLVERR;
        end
      endcase
    end
    else if (st_r.rvalid && S_AXI_RREADY)
      st_nxt.rvalid = 1'b0;

    // master engine
    unique case (st_r.mstate)
      spc_pkg::MS_IDLE:
      begin
        st_nxt.sck = st_r.ctrl1[`SPC_C1_CKP];
        st_nxt.h   = 6'h00;
        st_nxt.fs  = 1'b0;
        if (st_r.en && master && st_r.tbf && !st_r.ctrl1[`SPC_C1_CLKDIS]
            && (!fr_in || fr_act))
        begin
          st_nxt.sr  = st_r.txb;
          st_nxt.tbf = 1'b0;
          st_nxt.rx  = 16'h0000;
          // precede the first bit clock by one period, or coincide
          st_nxt.mstate = (fr_out && !st_r.ctrl2[`SPC_C2_FDLY]) ? spc_pkg::MS_SYNC
                                                                : spc_pkg::MS_SHIFT;
        end
      end
      spc_pkg::MS_SYNC:
      begin
        if (tick)
        begin
          st_nxt.h = st_r.h + 6'h01;
          // pulse fills the whole period before the first bit clock
          if (st_r.h == 6'h00)
            st_nxt.fs = 1'b1;
          if (st_r.h == 6'h01)
          begin
            st_nxt.h      = 6'h00;
            st_nxt.mstate = spc_pkg::MS_SHIFT;
          end
        end
      end
      spc_pkg::MS_SHIFT:
      begin
        if (tick)
        begin
          st_nxt.h = st_r.h + 6'h01;
          // one clock period, starting at or ending at the first bit clock
          if (st_r.h == 6'h00)
            st_nxt.fs = fr_out && st_r.ctrl2[`SPC_C2_FDLY];
          if (st_r.h == 6'h02)
            st_nxt.fs = 1'b0;
          // toggle away from idle and back
          if (st_r.h != two_b)
            st_nxt.sck = !st_r.sck;
          if (samp_m)
            st_nxt.rx = {st_r.rx[14:0], st_r.s2[1]};
          // data moves only on the chosen edge
          if (shift_m)
            st_nxt.sr = {st_r.sr[14:0], 1'b0};
          // word ends after all of its clocks
          if (st_r.h == two_b)
          begin
            deliver       = 1'b1;
            st_nxt.mstate = spc_pkg::MS_IDLE;
          end
        end
      end
    endcase

    // slave engine; SCK is an input here
    if (st_r.en && !master)
    begin
      // incoming sync restarts the word count
      if (fr_in && fr_act)
        st_nxt.scnt = 5'h00;
      else if (!sel)
        st_nxt.scnt = 5'h00;
      else
      begin
        if (s_smp)
        begin
          st_nxt.rx   = {st_r.rx[14:0], st_r.s2[1]};
          st_nxt.scnt = st_r.scnt + 5'h01;
          if (st_r.scnt + 5'h01 == nbits)
          begin
            deliver     = 1'b1;
            st_nxt.scnt = 5'h00;
          end
        end
        if (s_chg && st_r.scnt != 5'h00)
          st_nxt.sr = {st_r.sr[14:0], 1'b0};
      end
      if (st_r.scnt == 5'h00 && st_r.tbf && !s_smp && !s_chg)
      begin
        st_nxt.sr  = st_r.txb;
        st_nxt.tbf = 1'b0;
      end
    end

    // completed word moves from shift register to receive buffer, or sets overflow if the buffer is still full
    if (deliver)
    begin
      if (st_nxt.rbf)
      begin
        st_nxt.rov = 1'b1;
        rov_set    = 1'b1;
      end
      else
      begin
        st_nxt.rxb = st_r.ctrl1[`SPC_C1_WIDE] ? st_nxt.rx : {8'h00, st_nxt.rx[7:0]};
        st_nxt.rbf = 1'b1;
      end
    end

    if (!st_r.en)
    begin
      st_nxt.mstate = spc_pkg::MS_IDLE;
      st_nxt.scnt   = 5'h00;
      st_nxt.fs     = 1'b0;
    end

    // write channel last, so a new buffer write survives a same-cycle load
    if (!st_r.aw_have && !st_r.bvalid && S_AXI_AWVALID)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = S_AXI_AWADDR;
    end
    if (!st_r.w_have && !st_r.bvalid && S_AXI_WVALID)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = S_AXI_WDATA[15:0];
      st_nxt.wstrb  = S_AXI_WSTRB[1:0];
    end
    if (st_r.aw_have && st_r.w_have)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = `SPC_RESP_OKAY;
      unique case (st_r.awaddr)
        `SPC_OFF_CTRL1:
        begin
          wmerge = st_r.ctrl1;
          if (st_r.wstrb[0]) wmerge[7:0] = st_r.wdata[7:0];
          if (st_r.wstrb[1]) wmerge[15:8] = st_r.wdata[15:8];
          st_nxt.ctrl1 = wmerge & `SPC_MASK_CTRL1;
        end
        `SPC_OFF_CTRL2:
        begin
          wmerge = st_r.ctrl2;
          if (st_r.wstrb[0]) wmerge[7:0] = st_r.wdata[7:0];
          if (st_r.wstrb[1]) wmerge[15:8] = st_r.wdata[15:8];
          st_nxt.ctrl2 = wmerge & `SPC_MASK_CTRL2;
        end
        `SPC_OFF_STAT:
        begin
          if (st_r.wstrb[1]) st_nxt.en = st_r.wdata[`SPC_ST_EN];
          // overflow clears on a written zero unless set this cycle
          if (st_r.wstrb[0] && !st_r.wdata[`SPC_ST_ROV] && !rov_set)
            st_nxt.rov = 1'b0;
        end
        `SPC_OFF_BUF:
        begin
          wmerge = st_r.txb;
          if (st_r.wstrb[0]) wmerge[7:0] = st_r.wdata[7:0];
          if (st_r.wstrb[1]) wmerge[15:8] = st_r.wdata[15:8];
          st_nxt.txb = wmerge;
          st_nxt.tbf = 1'b1;
        end
        default: st_nxt.bresp = `SPC_RESP_SLVERR;
      endcase
    end
    else if (st_r.bvalid && S_AXI_BREADY)
      st_nxt.bvalid = 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    // every control bit resets to zero
    if (!RST_N)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////
  assign S_AXI_AWREADY = !st_r.aw_have && !st_r.bvalid;
  assign S_AXI_WREADY  = !st_r.w_have && !st_r.bvalid;
  assign S_AXI_BVALID  = st_r.bvalid;
  assign S_AXI_BRESP   = st_r.bresp;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_RVALID  = st_r.rvalid;
  assign S_AXI_RDATA   = st_r.rdata;
  assign S_AXI_RRESP   = st_r.rresp;

  // clock pin driven only by an enabled master
  assign SERIAL_CLOCK_PIN_O  = st_r.sck;
  assign SERIAL_CLOCK_PIN_OE = st_r.en && master && !st_r.ctrl1[`SPC_C1_CLKDIS];
  // data pin released when disabled or deselected
  assign SERIAL_DATA_OUT_PIN_O  = st_r.ctrl1[`SPC_C1_WIDE] ? st_r.sr[15] : st_r.sr[7];
  assign SERIAL_DATA_OUT_PIN_OE = st_r.en && !st_r.ctrl1[`SPC_C1_SDODIS] && (master || sel);
  // select pin carries the sync pulse when framed with FSD clear
  assign SLAVE_SELECT_PIN_N_O  = st_r.fs ? st_r.ctrl2[`SPC_C2_FPOL] : !st_r.ctrl2[`SPC_C2_FPOL];
  assign SLAVE_SELECT_PIN_N_OE = st_r.en && fr_out;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence sync_go;
    st_r.mstate == spc_pkg::MS_IDLE && st_nxt.mstate != spc_pkg::MS_IDLE && fr_out
      && !st_r.ctrl2[`SPC_C2_FDLY];
  endsequence

  sequence sync_held;
    st_r.mstate == spc_pkg::MS_SYNC && st_r.fs;
  endsequence

  sequence sync_wait;
    st_r.mstate == spc_pkg::MS_SYNC && !st_r.fs && tick;
  endsequence

  clk_pin_release_a: assert property (
    st_r.ctrl1[`SPC_C1_CLKDIS] |-> !SERIAL_CLOCK_PIN_OE)
    else $error("clock pin driven while disabled");

  data_pin_release_a: assert property (
    st_r.ctrl1[`SPC_C1_SDODIS] |-> !SERIAL_DATA_OUT_PIN_OE)
    else $error("data pin driven while disabled");

  word_length_a: assert property (
    (st_r.mstate == spc_pkg::MS_SHIFT && deliver) |->
      st_r.h == (st_r.ctrl1[`SPC_C1_WIDE] ? 6'd32 : 6'd16))
    else $error("word ended after wrong clock count");

  sample_phase_a: assert property (
    (st_r.mstate == spc_pkg::MS_SHIFT && tick && st_r.ctrl1[`SPC_C1_SMP] && chg_m
      && st_r.h != 6'h00) |=> st_r.rx == {$past(st_r.rx[14:0]), $past(st_r.s2[1])})
    else $error("end sampling off the change edge");

  data_edge_a: assert property (
    (st_r.mstate == spc_pkg::MS_SHIFT && $past(st_r.mstate) == spc_pkg::MS_SHIFT
      && $changed(st_r.sr)) |-> $past(tick) && $past(chg_m))
    else $error("data moved on the wrong edge");

  select_gate_a: assert property (
    (st_r.en && !master && select_pin_enable_eff && st_r.s2[0]) |-> !SERIAL_DATA_OUT_PIN_OE)
    else $error("deselected slave drives data");

  clock_idle_a: assert property (
    (st_r.mstate == spc_pkg::MS_IDLE && $past(st_r.mstate) == spc_pkg::MS_IDLE)
      |-> SERIAL_CLOCK_PIN_O == $past(st_r.ctrl1[`SPC_C1_CKP]))
    else $error("clock not at idle level");

  master_dir_a: assert property (
    !master |-> !SERIAL_CLOCK_PIN_OE)
    else $error("slave drives the clock pin");

  sync_dir_a: assert property (
    (st_r.en && fr_in) |-> !SLAVE_SELECT_PIN_N_OE)
    else $error("sync input driven as output");

  sync_pulse_a: assert property (
    sync_go |=> sync_wait ##1 sync_held ##[1:1000]
      (!st_r.fs && st_r.mstate == spc_pkg::MS_SHIFT && st_r.h == 6'h01))
    else $error("preceding sync pulse misplaced");

  ctrl_read_a: assert property (
    (S_AXI_RVALID && st_r.raddr == `SPC_OFF_CTRL2) |-> S_AXI_RDATA[12:2] == 11'h000
      && S_AXI_RDATA[0] == 1'b0)
    else $error("reserved bits read non-zero");

endmodule

// ### tb/spc_peer.sv
`timescale 1ns/1ps
module spc_peer
(
  // clock and link pins
  input  wire logic        clk,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso,
  // word control
  input  wire logic        load,
  input  wire logic        pre,
  input  wire logic        wide,
  input  wire logic [15:0] tx,
  output logic [15:0]      rx
);
  logic [16:0] sh;
  logic        sck_q;
  logic [15:0] txa;
  assign txa  = wide ? tx : {tx[7:0], 8'h00};
  assign miso = sh[16];
  always_ff @(posedge clk)
  begin
    sck_q <= sck;
    if (load)
    begin
      sh <= pre ? {txa, 1'b0} : {~txa[15], txa};
      rx <= 16'h0000;
    end
    else if (sck && !sck_q)
      rx <= {rx[14:0], mosi};
    // spent bits are inverted so stale data never looks valid
    else if (!sck && sck_q)
      sh <= {sh[15:0], ~sh[0]};
  end
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "spc_consts.svh"
module testbench;
  logic        clk;
  logic        rst_n;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        sck_o;
  logic        sck_oe;
  logic        sdo;
  logic        sdo_oe;
  logic        sdi;
  logic        ss_o;
  logic        ss_oe;
  logic        p_load;
  logic        p_pre;
  logic        p_wide;
  logic [15:0] p_tx;
  logic [15:0] p_rx;
  logic [31:0] d;
  logic [1:0]  r;
  integer      num_errors;
  integer      tests_run;
  integer      fs_cnt;
  logic [7:0]  t_a [5];
  logic [31:0] t_w [5];
  logic [31:0] t_r [5];
  logic [1:0]  t_e [5];

  spc_top u_spc_top
  (
    .REF_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SERIAL_CLOCK_PIN_I(1'b0), .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
    .SERIAL_DATA_OUT_PIN_O(sdo), .SERIAL_DATA_OUT_PIN_OE(sdo_oe), .SERIAL_DATA_IN_PIN_I(sdi),
    .SLAVE_SELECT_PIN_N_I(1'b1), .SLAVE_SELECT_PIN_N_O(ss_o), .SLAVE_SELECT_PIN_N_OE(ss_oe)
  );

  spc_peer u_spc_peer
  (
    .clk(clk), .sck(sck_o), .mosi(sdo), .miso(sdi),
    .load(p_load), .pre(p_pre), .wide(p_wide), .tx(p_tx), .rx(p_rx)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
    if (ss_oe === 1'b1 && ss_o === 1'b1)
      fs_cnt = fs_cnt + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic xfer(input logic [15:0] c1, input logic pre, input logic wide,
                      input logic [15:0] mo, input logic [15:0] mi, input string nm);
    logic [15:0] m;
    m = wide ? 16'hFFFF : 16'h00FF;
    axi_wr(`SPC_OFF_CTRL1, {16'h0000, c1}, r);
    @(posedge clk);
    p_load <= 1'b1;
    p_pre  <= pre;
    p_wide <= wide;
    p_tx   <= mi;
    @(posedge clk);
    p_load <= 1'b0;
    axi_wr(`SPC_OFF_BUF, {16'h0000, mo}, r);
    do axi_rd(`SPC_OFF_STAT, d, r); while (d[0] !== 1'b1);
    axi_rd(`SPC_OFF_BUF, d, r);
    chk({nm, " rx"}, {16'h0000, mi & m}, d);
    chk({nm, " tx"}, {16'h0000, mo & m}, {16'h0000, p_rx & m});
    $display("test %s done", nm);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired");
    num_errors++;
    final_report();
  end

  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {p_load, p_pre, p_wide, p_tx} = '0;
    num_errors = 0;
    tests_run  = 0;
    fs_cnt     = 0;
    rst_n      = 1'b0;
    // unmapped address refused, reserved bits masked; bit 0 kept clear
    t_a = '{`SPC_OFF_CTRL1, `SPC_OFF_CTRL1, `SPC_OFF_CTRL2, `SPC_OFF_CTRL2, 8'h10};
    t_w = '{32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFE, 32'h0000_0000, 32'h1234_5678};
    t_r = '{32'h0000_1FFF, 32'h0000_0000, 32'h0000_E002, 32'h0000_0000, 32'h0000_0000};
    t_e = '{`SPC_RESP_OKAY, `SPC_RESP_OKAY, `SPC_RESP_OKAY, `SPC_RESP_OKAY, `SPC_RESP_SLVERR};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("oe after reset", 32'h0, {29'h0, sck_oe, sdo_oe, ss_oe});
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(8'(4 * i), d, r);
      chk("reset value", 32'h0000_0000, d);
    end
    for (int i = 0; i < 5; i++)
    begin
      axi_wr(t_a[i], t_w[i], r);
      chk("write resp", {30'h0, t_e[i]}, {30'h0, r});
      axi_rd(t_a[i], d, r);
      chk("read back", t_r[i], d);
      chk("read resp", {30'h0, t_e[i]}, {30'h0, r});
    end
    $display("test registers done");
    axi_wr(`SPC_OFF_STAT, 32'h0000_8000, r);
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_0000, r); // slave keeps sample phase clear
    repeat (3) @(posedge clk);
    chk("slave pins oe", 32'h1, {30'h0, sck_oe, sdo_oe});
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_0080, r);
    repeat (3) @(posedge clk);
    chk("deselected data oe", 32'h0, {31'h0, sdo_oe});
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_003D, r);
    repeat (3) @(posedge clk);
    chk("master pins", 32'h6, {29'h0, sck_oe, sdo_oe, sck_o});
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_007D, r);
    repeat (3) @(posedge clk);
    chk("idle high", 32'h1, {31'h0, sck_o});
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_183D, r);
    repeat (3) @(posedge clk);
    chk("pins released", 32'h0, {30'h0, sck_oe, sdo_oe});
    $display("test pins done");
    xfer(16'h033C, 1'b1, 1'b0, 16'h00A5, 16'h003C, "byte");
    xfer(16'h047D, 1'b0, 1'b1, 16'hC3A5, 16'h5A0F, "word");
    p_tx <= 16'h0F0F;
    p_load <= 1'b1;
    @(posedge clk);
    p_load <= 1'b0;
    axi_wr(`SPC_OFF_BUF, 32'h0000_1111, r);
    do axi_rd(`SPC_OFF_STAT, d, r); while (d[0] !== 1'b1);
    axi_wr(`SPC_OFF_BUF, 32'h0000_2222, r);
    do axi_rd(`SPC_OFF_STAT, d, r); while (d[6] !== 1'b1);
    chk("overflow status", 32'h0000_8041, d);
    axi_rd(`SPC_OFF_BUF, d, r);
    chk("kept word", 32'h0000_0F0F, d);
    axi_wr(`SPC_OFF_STAT, 32'h0000_8000, r);
    axi_rd(`SPC_OFF_STAT, d, r);
    chk("overflow cleared", 32'h0000_8000, d);
    $display("test overflow done");
    // clock edge and select enable kept clear when framed
    axi_wr(`SPC_OFF_CTRL1, 32'h0000_003D, r);
    axi_wr(`SPC_OFF_CTRL2, 32'h0000_A000, r);
    repeat (3) @(posedge clk);
    chk("sync out idle", 32'h2, {30'h0, ss_oe, ss_o});
    fs_cnt = 0;
    xfer(16'h003D, 1'b1, 1'b0, 16'h0081, 16'h0042, "framed");
    chk("sync width", 32'd16, 32'(fs_cnt));
    axi_wr(`SPC_OFF_CTRL2, 32'h0000_A002, r);
    fs_cnt = 0;
    xfer(16'h003D, 1'b1, 1'b0, 16'h0018, 16'h00E7, "coincident");
    chk("coincident width", 32'd16, 32'(fs_cnt));
    axi_wr(`SPC_OFF_CTRL2, 32'h0000_E000, r);
    repeat (3) @(posedge clk);
    chk("sync input", 32'h0, {31'h0, ss_oe});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(`SPC_OFF_CTRL2, d, r);
    chk("ctrl2 after reset", 32'h0, d);
    axi_rd(`SPC_OFF_CTRL1, d, r);
    chk("ctrl1 after reset", 32'h0, d);
    chk("oe after reset", 32'h0, {29'h0, sck_oe, sdo_oe, ss_oe});
    $display("test second reset done");
    final_report();
  end
endmodule
